// file: logic/spc_consts.vh
`ifndef SPC_CONSTS_VH
`define SPC_CONSTS_VH

// ************************************************************
// Register indices (byte address is four times the index)
// ************************************************************
`define SPC_IDX_DECEL_DIS      10'h15C
`define SPC_IDX_ACCEL_LEVEL    10'h15D
`define SPC_IDX_RUN_LEVEL      10'h15E
`define SPC_IDX_SUPPRESS_EN    10'h173
`define SPC_IDX_RAMP_SEL       10'h174
`define SPC_IDX_STATUS         10'h180
`define SPC_IDX_EFF_LIMIT      10'h181

// ************************************************************
// Reset values and setting ranges (percent of rated current)
// ************************************************************
`define SPC_RST_DECEL_DIS      1'h0
`define SPC_RST_ACCEL_LEVEL    8'hAA
`define SPC_RST_RUN_LEVEL      8'hA0
`define SPC_RST_SUPPRESS_EN    1'h0
`define SPC_RST_RAMP_SEL       1'h0
`define SPC_LEVEL_MIN          8'h1E
`define SPC_LEVEL_MAX          8'hC8

// ************************************************************
// Status register bit positions
// ************************************************************
`define SPC_ST_ACCEL_HOLD      0
`define SPC_ST_DECEL_HOLD      1
`define SPC_ST_RUN_REDUCE      2
`define SPC_ST_RUN_RESTORE     3
`define SPC_ST_RAMP_SECOND     4
`define SPC_ST_SUPPRESSED      5

// ************************************************************
// Timing and divider
// ************************************************************
`define SPC_CLK_HZ             10000000
`define SPC_RUN_DELAY_MS       100
`define SPC_DIV_STEPS          5'h19
`define SPC_DIV_LAST           5'h01

`endif

// file: logic/spc_div.v
`timescale 1ns/1ps
`include "spc_consts.vh"

// Iterative restoring divider, one quotient bit per cycle, result saturates to 9 bits
module spc_div (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // Operands
    input  wire        start,
    input  wire [24:0] num,
    input  wire [15:0] den,
    // Result
    output reg         busy,
    output reg         done,
    output reg  [8:0]  quo
);

    reg  [24:0] q;
    reg  [16:0] rem;
    reg  [15:0] d;
    reg  [4:0]  cnt;
    wire [16:0] shifted;
    wire [17:0] diff;
    wire [24:0] q_last;

    // Trial subtraction of the divisor from the shifted remainder
    assign shifted = {rem[15:0], q[24]};
    assign diff    = {1'b0, shifted} - {2'b00, d};
    assign q_last  = {q[23:0], ~diff[17]};

    // One step per cycle; a zero divisor yields all ones and saturates
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q    <= 25'h0000000;
            rem  <= 17'h00000;
            d    <= 16'h0000;
            cnt  <= 5'h00;
            busy <= 1'b0;
            done <= 1'b0;
            quo  <= 9'h000;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                q    <= num;
                rem  <= 17'h00000;
                d    <= den;
                cnt  <= `SPC_DIV_STEPS;
                busy <= 1'b1;
            end else if (busy) begin
                q   <= q_last;
                rem <= diff[17] ? shifted : diff[16:0];
                cnt <= cnt - 5'h01;
                if (cnt == `SPC_DIV_LAST) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    quo  <= (q_last[24:9] != 16'h0000) ? 9'h1FF : q_last[8:0];
                end
            end
        end
    end

endmodule // spc_div

// file: logic/spc_stall_ctrl.v
`timescale 1ns/1ps
`include "spc_consts.vh"

module spc_stall_ctrl #(
    parameter RUN_DELAY_CYC = (`SPC_RUN_DELAY_MS * `SPC_CLK_HZ) / 1000
) (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    // Drive state
    input  wire        accelerating,
    input  wire        decelerating,
    input  wire        running,
    input  wire        ramp_set2_selected,
    input  wire        dc_overvoltage,
    // Measurements, current in percent of rated inverter current
    input  wire [8:0]  out_current_pct,
    input  wire [15:0] out_freq,
    input  wire [15:0] freq_ref,
    input  wire [15:0] max_voltage_frequency,
    // Commands to the frequency ramp
    output reg         accel_hold,
    output reg         decel_hold,
    output reg         run_reduce,
    output reg         run_restore,
    output reg         ramp_use_second,
    output reg  [8:0]  run_limit_eff
);

    // ************************************************************
    // Running-state machine
    // ************************************************************
    // One-hot codes keep each state decode down to a single bit
    localparam [3:0] ST_NORMAL  = 4'h1;
    localparam [3:0] ST_OVER    = 4'h2;
    localparam [3:0] ST_REDUCE  = 4'h4;
    localparam [3:0] ST_RESTORE = 4'h8;
    // Compare value for the 20-bit delay count, cut to that width on purpose
    localparam [31:0] DELAY_FULL = RUN_DELAY_CYC - 1;
    localparam [19:0] DELAY_LAST = DELAY_FULL[19:0];

    // ************************************************************
    // Configuration registers
    // ************************************************************
    // Settings as software sees them, levels clamped on write
    reg        decel_stall_disable;
    reg  [7:0] accel_stall_level;
    reg  [7:0] run_stall_level;
    reg        stall_level_suppress_enable;
    reg        stall_ramp_time_select;

    // Run-state bookkeeping and bus decode helpers
    reg  [3:0]  state;
    reg  [3:0]  next_state;
    reg  [19:0] over_cnt;
    reg  [8:0]  scaled_limit;
    reg         suppressed;
    reg  [31:0] next_rdata;
    reg         addr_hit;

    // Decode, divider and compare nets
    wire [9:0]  idx;
    wire        setup_ph;
    wire        wr_en;
    wire [7:0]  wr_level;
    wire        above_vmax;
    wire        div_busy;
    wire        div_done;
    wire [8:0]  div_quo;
    wire [24:0] div_num;
    wire        over_run;
    wire        under_run;

    // ************************************************************
    // APB slave
    // ************************************************************
    // Zero wait states: read data is prepared in the setup cycle
    assign idx      = paddr[11:2];
    assign setup_ph = psel & ~penable;
    assign wr_en    = psel & penable & pwrite & addr_hit;
    assign pready   = 1'b1;
    // Error only in the access phase, so a setup cycle never flags
    assign pslverr  = psel & penable & ~addr_hit;

    // Out-of-range levels are clamped so the limits always stay meaningful
    // Only pwdata[15:0] is judged; the upper half word is ignored
    assign wr_level = (pwdata[15:0] < {8'h00, `SPC_LEVEL_MIN}) ? `SPC_LEVEL_MIN :
                      (pwdata[15:0] > {8'h00, `SPC_LEVEL_MAX}) ? `SPC_LEVEL_MAX : pwdata[7:0];

    // Address decode and read multiplexer
    always @* begin
        addr_hit   = 1'b1;
        next_rdata = 32'h00000000;
        case (idx)
            `SPC_IDX_DECEL_DIS:   next_rdata[0] = decel_stall_disable;
            `SPC_IDX_ACCEL_LEVEL: next_rdata[7:0] = accel_stall_level;
            `SPC_IDX_RUN_LEVEL:   next_rdata[7:0] = run_stall_level;
            `SPC_IDX_SUPPRESS_EN: next_rdata[0] = stall_level_suppress_enable;
            `SPC_IDX_RAMP_SEL:    next_rdata[0] = stall_ramp_time_select;
            `SPC_IDX_STATUS: begin
                next_rdata[`SPC_ST_ACCEL_HOLD]  = accel_hold;
                next_rdata[`SPC_ST_DECEL_HOLD]  = decel_hold;
                next_rdata[`SPC_ST_RUN_REDUCE]  = run_reduce;
                next_rdata[`SPC_ST_RUN_RESTORE] = run_restore;
                next_rdata[`SPC_ST_RAMP_SECOND] = ramp_use_second;
                next_rdata[`SPC_ST_SUPPRESSED]  = suppressed;
            end
            `SPC_IDX_EFF_LIMIT:   next_rdata[8:0] = run_limit_eff;
            default: begin
                addr_hit   = 1'b0;
                next_rdata = 32'h00000000;
            end
        endcase
    end

    // Read data register, loaded in the setup cycle of a read
    // Holding prdata between reads keeps the bus quiet
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup_ph && !pwrite) begin
            prdata <= next_rdata;
        end
    end

    // Register writes take effect at the access edge; status words ignore writes
    // The two read-only words fall to the default arm, so writes there are dropped
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            decel_stall_disable         <= `SPC_RST_DECEL_DIS;
            accel_stall_level           <= `SPC_RST_ACCEL_LEVEL;
            run_stall_level             <= `SPC_RST_RUN_LEVEL;
            stall_level_suppress_enable <= `SPC_RST_SUPPRESS_EN;
            stall_ramp_time_select      <= `SPC_RST_RAMP_SEL;
        end else if (wr_en) begin
            case (idx)
                `SPC_IDX_DECEL_DIS:   decel_stall_disable <= pwdata[0];
                `SPC_IDX_ACCEL_LEVEL: accel_stall_level <= wr_level;
                `SPC_IDX_RUN_LEVEL:   run_stall_level <= wr_level;
                `SPC_IDX_SUPPRESS_EN: stall_level_suppress_enable <= pwdata[0];
                `SPC_IDX_RAMP_SEL:    stall_ramp_time_select <= pwdata[0];
                default: begin
                    decel_stall_disable <= decel_stall_disable;
                end
            endcase
        end
    end

    // ************************************************************
    // Running limit suppression above the max voltage frequency
    // ************************************************************
    // The divider runs back to back, so the scaled limit trails the
    // frequency by about 26 cycles; the frequency moves far slower
    // A zero output frequency saturates the quotient, and the minimum taken
    // below then falls back to the configured level
    assign above_vmax = out_freq > max_voltage_frequency;
    assign div_num    = {1'b0, run_stall_level} * max_voltage_frequency;

    // Free running: start stays high and a new division begins as one ends
    spc_div u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (1'b1),
        .num     (div_num),
        .den     (out_freq),
        .busy    (div_busy),
        .done    (div_done),
        .quo     (div_quo)
    );

    // Latest quotient, never above the configured level
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scaled_limit <= {1'b0, `SPC_RST_RUN_LEVEL};
        end else if (div_done && !div_busy) begin
            scaled_limit <= (div_quo > {1'b0, run_stall_level}) ? {1'b0, run_stall_level} : div_quo;
        end
    end

    // Effective running limit, percent of rated current
    // Registered so the running compare never sees a half-updated limit
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_limit_eff <= {1'b0, `SPC_RST_RUN_LEVEL};
            suppressed    <= 1'b0;
        end else if (stall_level_suppress_enable && above_vmax) begin
            run_limit_eff <= scaled_limit;
            suppressed    <= 1'b1;
        end else begin
            run_limit_eff <= {1'b0, run_stall_level};
            suppressed    <= 1'b0;
        end
    end

    // ************************************************************
    // Acceleration and deceleration handling
    // ************************************************************
    // Each condition is judged on its own and has its own output
    // The holds drop by themselves once the cause goes; software never clears them
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accel_hold      <= 1'b0;
            decel_hold      <= 1'b0;
            ramp_use_second <= 1'b0;
        end else begin
            // Pause only above the limit; equal still accelerates
            accel_hold <= accelerating & (out_current_pct > {1'b0, accel_stall_level});
            // Stretch only when enabled; disabled means the set ramp is kept
            // even if the bus overvolts, which a braking resistor then absorbs
            decel_hold <= decelerating & ~decel_stall_disable & dc_overvoltage;
            // Normal selection may already pick set two; the setting only forces it
            ramp_use_second <= stall_ramp_time_select | ramp_set2_selected;
        end
    end

    // ************************************************************
    // Running stall handling
    // ************************************************************
    // Equal current is neither over nor under, so REDUCE holds at the boundary while OVER drops back to NORMAL
    assign over_run  = out_current_pct > run_limit_eff;
    assign under_run = out_current_pct < run_limit_eff;

    // Next-state logic: overcurrent must persist for the full delay
    // Leaving the running condition clears every state so a restart begins clean
    always @* begin
        next_state = state;
        case (state)
            ST_NORMAL: begin
                if (running && over_run) next_state = ST_OVER;
            end
            ST_OVER: begin
                if (!running || !over_run) next_state = ST_NORMAL;
                else if (over_cnt == DELAY_LAST) next_state = ST_REDUCE;
            end
            ST_REDUCE: begin
                if (!running) next_state = ST_NORMAL;
                else if (under_run) next_state = ST_RESTORE;
            end
            ST_RESTORE: begin
                if (!running) next_state = ST_NORMAL;
                else if (over_run) next_state = ST_OVER;
                else if (out_freq >= freq_ref) next_state = ST_NORMAL;
            end
            default: begin
                next_state = ST_NORMAL;
            end
        endcase
    end

    // State register and persistence counter
    // The count only runs in OVER, so any dropout restarts the full delay
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state    <= ST_NORMAL;
            over_cnt <= 20'h00000;
        end else begin
            state <= next_state;
            if (state == ST_OVER && next_state == ST_OVER) begin
                over_cnt <= over_cnt + 20'h00001;
            end else begin
                over_cnt <= 20'h00000;
            end
        end
    end

    // Ramp commands for the running condition
    // Taken from next_state so the command moves on the same edge as the state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_reduce  <= 1'b0;
            run_restore <= 1'b0;
        end else begin
            run_reduce  <= (next_state == ST_REDUCE);
            run_restore <= (next_state == ST_RESTORE);
        end
    end

endmodule // spc_stall_ctrl

// file: test/spc_chk_asserts.sv
`timescale 1ns/1ps

// ************************************************************
// Stall control port checker
// ************************************************************
module spc_chk #(
    parameter RUN_DELAY_CYC = 20
) (
    // Clock and reset
    input wire       pclk,
    input wire       presetn,
    // Bus
    input wire       psel,
    input wire       penable,
    input wire       pready,
    input wire       pslverr,
    // Drive state and measurements
    input wire       accelerating,
    input wire       decelerating,
    input wire       running,
    input wire       ramp_set2_selected,
    input wire       dc_overvoltage,
    input wire [8:0] out_current_pct,
    // Commands
    input wire       accel_hold,
    input wire       decel_hold,
    input wire       run_reduce,
    input wire       run_restore,
    input wire       ramp_use_second,
    input wire [8:0] run_limit_eff
);
    reg [20:0] over_cnt;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Run of consecutive over-limit samples, saturating so it never wraps back to zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) over_cnt <= 21'h0;
        else if (!(running && out_current_pct > run_limit_eff)) over_cnt <= 21'h0;
        else if (!over_cnt[20]) over_cnt <= over_cnt + 21'h1;
    end

    chk_accel_over:  assert property (accelerating && out_current_pct > 9'h0C8 |=> accel_hold)
        else $error("accel hold missing above top limit");
    chk_accel_free:  assert property (!accelerating || out_current_pct <= 9'h01E |=> !accel_hold)
        else $error("accel hold without cause");
    chk_decel_cause: assert property (!(decelerating && dc_overvoltage) |=> !decel_hold)
        else $error("decel hold without overvoltage");
    chk_ramp_second: assert property (ramp_set2_selected |=> ramp_use_second)
        else $error("second ramp set not used");
    chk_run_delay:   assert property ($rose(run_reduce) |-> over_cnt >= RUN_DELAY_CYC)
        else $error("run reduce before delay");
    chk_run_stop:    assert property (!running |=> !run_reduce && !run_restore)
        else $error("run command while not running");
    chk_run_excl:    assert property (!(run_reduce && run_restore))
        else $error("reduce and restore together");
    chk_restore_src: assert property ($rose(run_restore) |-> $past(run_reduce))
        else $error("restore without prior reduce");
    chk_limit_top:   assert property (run_limit_eff <= 9'h0C8)
        else $error("effective limit above range");
    chk_err_phase:   assert property (pslverr |-> psel && penable && pready)
        else $error("error outside access phase");

    cov_accel:   cover property (accel_hold);
    cov_decel:   cover property (decel_hold);
    cov_reduce:  cover property ($rose(run_reduce));
    cov_restore: cover property ($fell(run_restore));
endmodule // spc_chk

bind spc_stall_ctrl spc_chk #(.RUN_DELAY_CYC(RUN_DELAY_CYC)) chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .accelerating(accelerating), .decelerating(decelerating),
    .running(running), .ramp_set2_selected(ramp_set2_selected), .dc_overvoltage(dc_overvoltage),
    .out_current_pct(out_current_pct), .accel_hold(accel_hold), .decel_hold(decel_hold),
    .run_reduce(run_reduce), .run_restore(run_restore), .ramp_use_second(ramp_use_second),
    .run_limit_eff(run_limit_eff));

// file: test/spc_motor.sv
`timescale 1ns/1ps

// ************************************************************
// Motor and ramp model: output frequency follows the commands
// ************************************************************
module spc_motor (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // Commands from the stall control
    input  wire        run_reduce,
    input  wire        run_restore,
    // Direct frequency preset from the bench
    input  wire        load_en,
    input  wire [15:0] load_freq,
    // Speed seen by the control
    output reg  [15:0] out_freq
);
    // One unit per cycle: slow enough that restore is seen for many cycles
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) out_freq <= 16'h0000;
        else if (load_en) out_freq <= load_freq;
        else if (run_reduce) out_freq <= out_freq - 16'h0001;
        else if (run_restore) out_freq <= out_freq + 16'h0001;
    end
endmodule // spc_motor

// file: test/tb.sv
`timescale 1ns/1ps
`include "spc_consts.vh"

// ************************************************************
// Stall control bench
// ************************************************************
module tb;
    logic        pclk, presetn, psel, penable, pwrite, acc, dec, run, set2, ovv, ld;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd_v;
    logic [8:0]  cur;
    logic [15:0] fref, fvmax, ldf;
    wire  [31:0] prdata;
    wire  [15:0] fout;
    wire  [8:0]  lim;
    wire         pready, pslverr, a_h, d_h, r_red, r_res, r2;
    logic        er_v;
    integer      errors, comparisons, i, n;
    logic [9:0]  ri [5];
    logic [31:0] rv [5];

    spc_stall_ctrl #(.RUN_DELAY_CYC(20)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .accelerating(acc), .decelerating(dec), .running(run),
        .ramp_set2_selected(set2), .dc_overvoltage(ovv), .out_current_pct(cur), .out_freq(fout),
        .freq_ref(fref), .max_voltage_frequency(fvmax), .accel_hold(a_h), .decel_hold(d_h),
        .run_reduce(r_red), .run_restore(r_res), .ramp_use_second(r2), .run_limit_eff(lim));
    spc_motor mot (.pclk(pclk), .presetn(presetn), .run_reduce(r_red), .run_restore(r_res),
        .load_en(ld), .load_freq(ldf), .out_freq(fout));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task test_done;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Setup then access; request held until pready is sampled high
    task apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
        integer k;
        @(posedge pclk);
        psel <= 1'b1; pwrite <= wr; paddr <= {idx, 2'b00}; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin errors++; test_done; end
        rd_v = prdata; er_v = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task rd_chk(input logic [9:0] idx, input logic [31:0] e, input logic ee);
        apb(1'b0, idx, 32'h0);
        check("prdata", rd_v, e);
        check("pslverr", {31'h0, er_v}, {31'h0, ee});
    endtask

    task tick(input integer c);
        repeat (c) @(posedge pclk);
        #1;
    endtask

    initial begin
        errors = 0; comparisons = 0;
        {presetn, psel, penable, pwrite, acc, dec, run, set2, ovv, ld} = 10'h0;
        paddr = 12'h000; pwdata = 32'h0; cur = 9'h000; fref = 16'h0078; fvmax = 16'h00C8; ldf = 16'h0064;
        ri = '{`SPC_IDX_DECEL_DIS, `SPC_IDX_ACCEL_LEVEL, `SPC_IDX_RUN_LEVEL, `SPC_IDX_SUPPRESS_EN, `SPC_IDX_RAMP_SEL};
        rv = '{32'h0, 32'hAA, 32'hA0, 32'h0, 32'h0};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 5; i++) rd_chk(ri[i], rv[i], 1'b0);
        rd_chk(10'h3FF, 32'h0, 1'b1);
        // Level above range lands on the top value
        apb(1'b1, `SPC_IDX_ACCEL_LEVEL, 32'hFA);
        rd_chk(`SPC_IDX_ACCEL_LEVEL, 32'hC8, 1'b0);
        apb(1'b1, `SPC_IDX_ACCEL_LEVEL, 32'h5);
        rd_chk(`SPC_IDX_ACCEL_LEVEL, 32'h1E, 1'b0);
        apb(1'b1, `SPC_IDX_ACCEL_LEVEL, 32'h64);
        @(posedge pclk); acc <= 1'b1; cur <= 9'h065;
        tick(3); check("accel_hold", a_h, 1);
        @(posedge pclk); cur <= 9'h0C9;
        tick(3); check("accel_hold", a_h, 1);
        @(posedge pclk); cur <= 9'h064;
        tick(3); check("accel_hold", a_h, 0);
        @(posedge pclk); acc <= 1'b0; dec <= 1'b1; ovv <= 1'b1;
        tick(3); check("decel_hold", d_h, 1);
        apb(1'b1, `SPC_IDX_DECEL_DIS, 32'h1);
        tick(3); check("decel_hold", d_h, 0);
        check("ramp_use_second", r2, 0);
        @(posedge pclk); dec <= 1'b0; ovv <= 1'b0; set2 <= 1'b1;
        tick(3); check("ramp_use_second", r2, 1);
        @(posedge pclk); set2 <= 1'b0;
        apb(1'b1, `SPC_IDX_RAMP_SEL, 32'h1);
        tick(3); check("ramp_use_second", r2, 1);
        // Overload while running: reduce only after the delay, then restore to the reference
        @(posedge pclk); ld <= 1'b1; run <= 1'b1; cur <= 9'h0AA;
        @(posedge pclk); ld <= 1'b0;
        n = 0;
        while (r_red !== 1'b1 && n < 200) begin tick(1); n++; end
        check("run_reduce", r_red, 1);
        check("reduce_delay", {31'h0, n >= 20}, 1);
        @(posedge pclk); cur <= 9'h096;
        tick(2); check("run_restore", r_res, 1);
        n = 0;
        while (r_res !== 1'b0 && n < 500) begin tick(1); n++; end
        if (n >= 500) begin errors++; test_done; end
        check("freq_reached", {31'h0, fout >= fref}, 1);
        // Above the max voltage frequency the limit shrinks only when suppression is on
        @(posedge pclk); run <= 1'b0; fvmax <= 16'h0032; ld <= 1'b1;
        @(posedge pclk); ld <= 1'b0;
        tick(60); rd_chk(`SPC_IDX_EFF_LIMIT, 32'hA0, 1'b0);
        apb(1'b1, `SPC_IDX_SUPPRESS_EN, 32'h1);
        tick(60); rd_chk(`SPC_IDX_EFF_LIMIT, 32'h50, 1'b0);
        check("run_limit_eff", lim, 32'h50);
        // Status: second ramp set forced and the limit suppressed, all holds idle
        rd_chk(`SPC_IDX_STATUS, 32'h30, 1'b0);
        test_done;
    end
endmodule // tb
